/* File: rtl/unb_pkg.sv */
// Shared constants, types and helpers for the nine-bit multidrop serial link.
package unb_pkg;

	// ==========================================================
	// Frame modes
	localparam logic [1:0] MODE_7BIT = 2'h0;
	localparam logic [1:0] MODE_8BIT = 2'h1;
	localparam logic [1:0] MODE_ADDR_FLAG = 2'h2;
	localparam logic [1:0] MODE_9BIT = 2'h3;
	localparam int DEF_CLKS_PER_BIT = 16;

	// ==========================================================
	// Register port and map
	localparam int ADDR_W = 2;
	localparam int DATA_W = 16;
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_DATA = 2'h1;
	localparam logic [1:0] REG_STATUS = 2'h2;
	localparam logic [1:0] REG_MASK = 2'h3;

	// Control fields.
	localparam int CTRL_W = 7;
	localparam int CTRL_MODE_LOW = 0;
	localparam int CTRL_MODE_HIGH = 1;
	localparam int CTRL_PAR_EN = 2;
	localparam int CTRL_PAR_ODD = 3;
	localparam int CTRL_TX_EN = 4;
	localparam int CTRL_RX_EN = 5;
	localparam int CTRL_OUT_EN = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

	// Data register fields.
	localparam int DATA_NINTH = 8;
	localparam int DATA_PAR_ERR = 9;
	localparam int DATA_FRM_ERR = 10;

	// Status fields; the low N_EV bits are sticky events.
	localparam int N_EV = 4;
	localparam int EV_RX = 0;
	localparam int EV_TX = 1;
	localparam int EV_OVR = 2;
	localparam int EV_ERR = 3;
	localparam int ST_RX_FULL = 4;
	localparam int ST_TX_EMPTY = 5;
	localparam int ST_TX_BUSY = 6;
	localparam logic [N_EV-1:0] MASK_RESET = 4'h0;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {TX_IDLE, TX_START, TX_BITS, TX_STOP} unb_tx_state_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} unb_rx_state_t;

	// Number of character bits between start and stop for a mode.
	function automatic logic [3:0] unb_char_bits(input logic [1:0] mode);
		case (mode)
			MODE_7BIT: return 4'h7;
			MODE_8BIT: return 4'h8;
			default: return 4'h9;
		endcase
	endfunction

endpackage

/* File: rtl/unb_link_if.sv */
// Two serial lines between the device end and the far end, with line pull-up.
`timescale 1ns/10ps
`default_nettype none
interface unb_link_if;
	logic dev_sout;
	logic dev_sout_oe;
	logic far_sout;
	logic far_sout_oe;
	logic dev_rx;
	logic far_rx;

	// An undriven line idles high through its pull-up.
	assign dev_rx = far_sout_oe ? far_sout : 1'b1;
	assign far_rx = dev_sout_oe ? dev_sout : 1'b1;

	modport device(output dev_sout, output dev_sout_oe, input dev_rx);
	modport far(output far_sout, output far_sout_oe, input far_rx);
endinterface
`default_nettype wire

/* File: rtl/unb_device.sv */
// Nine-bit multidrop serial port with register port, interrupt and four frame modes.
//
// Functional notes
// - Two-bit field selects frame mode zero to three.
// - Parity steals one data bit in modes 0,1,3.
// - Mode 2 has no parity; ninth bit flags address.
// - Modes 2 and 3 always carry nine bits.
// - Modes 2,3 frame: start, nine bits, stop.
// - Line coding is plain NRZ only.
// - Mode 3 sends the register's ninth bit with parity off.
// - Sender sets ninth bit one for address.
// - Received ninth bit stored beside received byte.
// - Each received character flagged address or data.
// - Independent one-byte receive and transmit buffers.
// - Each buffer has interrupt and readable flag.
// - Master stays in mode 3 permanently.
// - Slave uses mode 2, mode 3 when addressed.
// - Mode 2 only for slaves, never host.
// - Mode 2 drops frames with ninth bit zero.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module unb_device #(
	parameter int CLKS_PER_BIT = unb_pkg::DEF_CLKS_PER_BIT
) (
	// System.
	input wire logic clk,
	input wire logic rst,
	// Register port.
	input wire logic [unb_pkg::ADDR_W-1:0] addr,
	input wire logic [unb_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [unb_pkg::DATA_W-1:0] rdata,
	// Interrupt.
	output logic irq,
	// Serial line.
	unb_link_if.device link
);
	import unb_pkg::*;

	localparam int CW = $clog2(CLKS_PER_BIT) + 1;
	localparam logic [CW-1:0] BIT_LAST = CW'(CLKS_PER_BIT - 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(CLKS_PER_BIT / 2 - 1);

	generate
		if (CLKS_PER_BIT < 4) begin : g_bad_rate
			$error("CLKS_PER_BIT must be at least 4.");
		end
	endgenerate

	// Mask covering the low n bits of a character.
	function automatic logic [8:0] low_mask(input logic [3:0] n);
		return (9'h001 << n) - 9'h001;
	endfunction

	// ==========================================================
	// Register group
	logic [CTRL_W-1:0] ctrl, next_ctrl;
	logic [N_EV-1:0] mask, next_mask, events, next_events;
	logic [8:0] tx_buf, next_tx_buf;
	logic tx_full, next_tx_full;
	logic [10:0] rx_buf, next_rx_buf;
	logic rx_full, next_rx_full;
	logic [DATA_W-1:0] next_rdata;
	logic next_irq;
	logic [1:0] mode;
	logic par_en;
	logic [N_EV-1:0] ev_set;
	logic tx_load, tx_busy;
	logic rx_done, rx_err;
	logic [10:0] rx_word;

	// Mode comes straight from the two-bit field; mode 2 forces parity off.
	assign mode = {ctrl[CTRL_MODE_HIGH], ctrl[CTRL_MODE_LOW]};
	assign par_en = ctrl[CTRL_PAR_EN] && (mode != MODE_ADDR_FLAG);
	assign ev_set = {rx_err, rx_done & rx_full, tx_load, rx_done};
	assign link.dev_sout_oe = ctrl[CTRL_OUT_EN];

	always_comb begin
		next_ctrl = ctrl;
		next_mask = mask;
		next_events = events;
		next_tx_buf = tx_buf;
		next_tx_full = tx_full;
		next_rx_buf = rx_buf;
		next_rx_full = rx_full;
		next_rdata = '0;
		if (wr) begin
			if (addr == REG_CTRL) begin
				next_ctrl = wdata[CTRL_W-1:0];
			end else if (addr == REG_DATA) begin
				// A write into a full transmit buffer is dropped.
				if (!tx_full) begin
					next_tx_buf = wdata[8:0];
					next_tx_full = 1'b1;
				end
			end else if (addr == REG_MASK) begin
				next_mask = wdata[N_EV-1:0];
			end
		end
		if (rd) begin
			if (addr == REG_CTRL) begin
				next_rdata = DATA_W'(ctrl);
			end else if (addr == REG_DATA) begin
				next_rdata = DATA_W'(rx_buf);
				next_rx_full = 1'b0;
			end else if (addr == REG_STATUS) begin
				next_rdata = DATA_W'({tx_busy, !tx_full, rx_full, events});
				next_events = '0;
			end else if (addr == REG_MASK) begin
				next_rdata = DATA_W'(mask);
			end
		end
		if (tx_load) begin
			next_tx_full = 1'b0;
		end
		// A new character wins over a read that empties the buffer.
		if (rx_done) begin
			next_rx_buf = rx_word;
			next_rx_full = 1'b1;
		end
		next_events = next_events | ev_set;
		next_irq = |(next_events & next_mask);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RESET;
			mask <= MASK_RESET;
			events <= '0;
			tx_buf <= '0;
			tx_full <= 1'b0;
			rx_buf <= '0;
			rx_full <= 1'b0;
			rdata <= '0;
			irq <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			mask <= next_mask;
			events <= next_events;
			tx_buf <= next_tx_buf;
			tx_full <= next_tx_full;
			rx_buf <= next_rx_buf;
			rx_full <= next_rx_full;
			rdata <= next_rdata;
			irq <= next_irq;
		end
	end

	// ==========================================================
	// Transmit group
	unb_tx_state_t tx_state, next_tx_state;
	logic [CW-1:0] tx_cnt, next_tx_cnt;
	logic [3:0] tx_idx, next_tx_idx, tx_len, next_tx_len;
	logic [8:0] tx_shift, next_tx_shift;
	logic sout, next_sout;
	logic [3:0] tx_dbits;
	logic [8:0] tx_char;

	assign tx_busy = (tx_state != TX_IDLE);
	assign link.dev_sout = sout;
	assign tx_dbits = unb_char_bits(mode) - 4'h1;

	// Parity takes the top character bit when enabled.
	always_comb begin
		if (par_en) begin
			tx_char = (tx_buf & low_mask(tx_dbits)) |
				(9'(^(tx_buf & low_mask(tx_dbits)) ^ ctrl[CTRL_PAR_ODD]) << tx_dbits);
		end else begin
			tx_char = tx_buf & low_mask(unb_char_bits(mode));
		end
	end

	always_comb begin
		next_tx_state = tx_state;
		next_tx_cnt = tx_cnt;
		next_tx_idx = tx_idx;
		next_tx_len = tx_len;
		next_tx_shift = tx_shift;
		next_sout = sout;
		tx_load = 1'b0;
		case (tx_state)
			TX_IDLE: begin
				next_sout = 1'b1;
				if (tx_full && ctrl[CTRL_TX_EN]) begin
					tx_load = 1'b1;
					next_tx_shift = tx_char;
					next_tx_len = unb_char_bits(mode);
					next_tx_cnt = '0;
					next_sout = 1'b0;
					next_tx_state = TX_START;
				end
			end
			TX_START: begin
				if (tx_cnt == BIT_LAST) begin
					next_tx_cnt = '0;
					next_tx_idx = '0;
					next_sout = tx_shift[0];
					next_tx_shift = tx_shift >> 1;
					next_tx_state = TX_BITS;
				end else begin
					next_tx_cnt = tx_cnt + CW'(1);
				end
			end
			TX_BITS: begin
				if (tx_cnt == BIT_LAST) begin
					next_tx_cnt = '0;
					if (tx_idx == tx_len - 4'h1) begin
						next_sout = 1'b1;
						next_tx_state = TX_STOP;
					end else begin
						next_tx_idx = tx_idx + 4'h1;
						next_sout = tx_shift[0];
						next_tx_shift = tx_shift >> 1;
					end
				end else begin
					next_tx_cnt = tx_cnt + CW'(1);
				end
			end
			default: begin
				if (tx_cnt == BIT_LAST) begin
					next_tx_state = TX_IDLE;
				end else begin
					next_tx_cnt = tx_cnt + CW'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_state <= TX_IDLE;
			tx_cnt <= '0;
			tx_idx <= '0;
			tx_len <= '0;
			tx_shift <= '0;
			sout <= 1'b1;
		end else begin
			tx_state <= next_tx_state;
			tx_cnt <= next_tx_cnt;
			tx_idx <= next_tx_idx;
			tx_len <= next_tx_len;
			tx_shift <= next_tx_shift;
			sout <= next_sout;
		end
	end

	// ==========================================================
	// Receive group
	unb_rx_state_t rx_state, next_rx_state;
	logic [CW-1:0] rx_cnt, next_rx_cnt;
	logic [3:0] rx_idx, next_rx_idx, rx_len, next_rx_len;
	logic [8:0] rx_shift, next_rx_shift;
	logic [8:0] rx_char;
	logic [3:0] rx_dbits;
	logic rx_ninth, rx_perr, rx_ferr;
	logic [8:0] rx_keep;

	// Bits arrive LSB first into the top, so right-align by the length.
	assign rx_char = rx_shift >> (4'h9 - rx_len);
	assign rx_dbits = rx_len - 4'h1;
	assign rx_ninth = !par_en && (rx_len == 4'h9) && rx_char[8];
	assign rx_perr = par_en && (^(rx_char & low_mask(rx_dbits)) ^ ctrl[CTRL_PAR_ODD] ^ rx_char[rx_dbits]);
	assign rx_ferr = !link.dev_rx;
	assign rx_keep = low_mask(par_en ? rx_dbits : rx_len);

	always_comb begin
		next_rx_state = rx_state;
		next_rx_cnt = rx_cnt;
		next_rx_idx = rx_idx;
		next_rx_len = rx_len;
		next_rx_shift = rx_shift;
		rx_done = 1'b0;
		rx_err = 1'b0;
		rx_word = {rx_ferr, rx_perr, rx_ninth, rx_char[7:0] & rx_keep[7:0]};
		case (rx_state)
			RX_IDLE: begin
				if (ctrl[CTRL_RX_EN] && !link.dev_rx) begin
					next_rx_cnt = '0;
					next_rx_len = unb_char_bits(mode);
					next_rx_state = RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt == HALF_LAST) begin
					next_rx_cnt = '0;
					next_rx_idx = '0;
					// A start bit gone by mid-bit is a glitch.
					next_rx_state = link.dev_rx ? RX_IDLE : RX_BITS;
				end else begin
					next_rx_cnt = rx_cnt + CW'(1);
				end
			end
			RX_BITS: begin
				if (rx_cnt == BIT_LAST) begin
					next_rx_cnt = '0;
					next_rx_shift = {link.dev_rx, rx_shift[8:1]};
					if (rx_idx == rx_len - 4'h1) begin
						next_rx_state = RX_STOP;
					end else begin
						next_rx_idx = rx_idx + 4'h1;
					end
				end else begin
					next_rx_cnt = rx_cnt + CW'(1);
				end
			end
			default: begin
				if (rx_cnt == BIT_LAST) begin
					next_rx_state = RX_IDLE;
					// Data frames are empty frames to a port in mode 2.
					if (!(mode == MODE_ADDR_FLAG && !rx_ninth)) begin
						rx_done = 1'b1;
						rx_err = rx_perr || rx_ferr;
					end
				end else begin
					next_rx_cnt = rx_cnt + CW'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_state <= RX_IDLE;
			rx_cnt <= '0;
			rx_idx <= '0;
			rx_len <= 4'h9;
			rx_shift <= '0;
		end else begin
			rx_state <= next_rx_state;
			rx_cnt <= next_rx_cnt;
			rx_idx <= next_rx_idx;
			rx_len <= next_rx_len;
			rx_shift <= next_rx_shift;
		end
	end

endmodule
`default_nettype wire

/* File: rtl/unb_far_end.sv */
// Far-end master serial port fixed in mode 3, always driving its line.
`timescale 1ns/10ps
`default_nettype none
module unb_far_end #(
	parameter int CLKS_PER_BIT = unb_pkg::DEF_CLKS_PER_BIT
) (
	// System.
	input wire logic clk,
	input wire logic rst,
	// Transmit request.
	input wire logic [7:0] tx_byte,
	input wire logic tx_address,
	input wire logic tx_valid,
	output logic tx_ready,
	// Receive result.
	output logic [7:0] rx_byte,
	output logic rx_address,
	output logic rx_frame_err,
	output logic rx_valid,
	// Serial line.
	unb_link_if.far link
);
	import unb_pkg::*;

	localparam int CW = $clog2(CLKS_PER_BIT) + 1;
	localparam logic [CW-1:0] BIT_LAST = CW'(CLKS_PER_BIT - 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(CLKS_PER_BIT / 2 - 1);
	localparam logic [3:0] LEN = unb_char_bits(MODE_9BIT);

	generate
		if (CLKS_PER_BIT < 4) begin : g_bad_rate
			$error("CLKS_PER_BIT must be at least 4.");
		end
	endgenerate

	// The master owns its line at all times.
	assign link.far_sout_oe = 1'b1;

	// ==========================================================
	// Transmit group
	unb_tx_state_t tx_state, next_tx_state;
	logic [CW-1:0] tx_cnt, next_tx_cnt;
	logic [3:0] tx_idx, next_tx_idx;
	logic [8:0] tx_shift, next_tx_shift;
	logic sout, next_sout;

	assign tx_ready = (tx_state == TX_IDLE);
	assign link.far_sout = sout;

	always_comb begin
		next_tx_state = tx_state;
		next_tx_cnt = tx_cnt;
		next_tx_idx = tx_idx;
		next_tx_shift = tx_shift;
		next_sout = sout;
		case (tx_state)
			TX_IDLE: begin
				next_sout = 1'b1;
				if (tx_valid) begin
					next_tx_shift = {tx_address, tx_byte};
					next_tx_cnt = '0;
					next_sout = 1'b0;
					next_tx_state = TX_START;
				end
			end
			TX_START, TX_BITS: begin
				if (tx_cnt == BIT_LAST) begin
					next_tx_cnt = '0;
					if (tx_state == TX_START) begin
						next_tx_idx = '0;
						next_sout = tx_shift[0];
						next_tx_shift = tx_shift >> 1;
						next_tx_state = TX_BITS;
					end else if (tx_idx == LEN - 4'h1) begin
						next_sout = 1'b1;
						next_tx_state = TX_STOP;
					end else begin
						next_tx_idx = tx_idx + 4'h1;
						next_sout = tx_shift[0];
						next_tx_shift = tx_shift >> 1;
					end
				end else begin
					next_tx_cnt = tx_cnt + CW'(1);
				end
			end
			default: begin
				if (tx_cnt == BIT_LAST) begin
					next_tx_state = TX_IDLE;
				end else begin
					next_tx_cnt = tx_cnt + CW'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_state <= TX_IDLE;
			tx_cnt <= '0;
			tx_idx <= '0;
			tx_shift <= '0;
			sout <= 1'b1;
		end else begin
			tx_state <= next_tx_state;
			tx_cnt <= next_tx_cnt;
			tx_idx <= next_tx_idx;
			tx_shift <= next_tx_shift;
			sout <= next_sout;
		end
	end

	// ==========================================================
	// Receive group
	unb_rx_state_t rx_state, next_rx_state;
	logic [CW-1:0] rx_cnt, next_rx_cnt;
	logic [3:0] rx_idx, next_rx_idx;
	logic [8:0] rx_shift, next_rx_shift;
	logic [7:0] next_rx_byte;
	logic next_rx_address, next_rx_frame_err, next_rx_valid;

	always_comb begin
		next_rx_state = rx_state;
		next_rx_cnt = rx_cnt;
		next_rx_idx = rx_idx;
		next_rx_shift = rx_shift;
		next_rx_byte = rx_byte;
		next_rx_address = rx_address;
		next_rx_frame_err = rx_frame_err;
		next_rx_valid = 1'b0;
		case (rx_state)
			RX_IDLE: begin
				if (!link.far_rx) begin
					next_rx_cnt = '0;
					next_rx_state = RX_START;
				end
			end
			RX_START: begin
				if (rx_cnt == HALF_LAST) begin
					next_rx_cnt = '0;
					next_rx_idx = '0;
					next_rx_state = link.far_rx ? RX_IDLE : RX_BITS;
				end else begin
					next_rx_cnt = rx_cnt + CW'(1);
				end
			end
			RX_BITS: begin
				if (rx_cnt == BIT_LAST) begin
					next_rx_cnt = '0;
					next_rx_shift = {link.far_rx, rx_shift[8:1]};
					if (rx_idx == LEN - 4'h1) begin
						next_rx_state = RX_STOP;
					end else begin
						next_rx_idx = rx_idx + 4'h1;
					end
				end else begin
					next_rx_cnt = rx_cnt + CW'(1);
				end
			end
			default: begin
				if (rx_cnt == BIT_LAST) begin
					next_rx_state = RX_IDLE;
					next_rx_byte = rx_shift[7:0];
					next_rx_address = rx_shift[8];
					next_rx_frame_err = !link.far_rx;
					next_rx_valid = 1'b1;
				end else begin
					next_rx_cnt = rx_cnt + CW'(1);
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_state <= RX_IDLE;
			rx_cnt <= '0;
			rx_idx <= '0;
			rx_shift <= '0;
			rx_byte <= '0;
			rx_address <= 1'b0;
			rx_frame_err <= 1'b0;
			rx_valid <= 1'b0;
		end else begin
			rx_state <= next_rx_state;
			rx_cnt <= next_rx_cnt;
			rx_idx <= next_rx_idx;
			rx_shift <= next_rx_shift;
			rx_byte <= next_rx_byte;
			rx_address <= next_rx_address;
			rx_frame_err <= next_rx_frame_err;
			rx_valid <= next_rx_valid;
		end
	end

endmodule
`default_nettype wire

/* File: test/unb_properties.sv */
// Concurrent checks on the serial link between the device end and the far end.
`timescale 1ns/10ps
`default_nettype none
module unb_properties #(
	parameter int CPB = 4
) (
	// System.
	input wire logic clk,
	input wire logic rst,
	// Link.
	input wire logic dev_sout,
	input wire logic dev_sout_oe,
	input wire logic far_sout,
	input wire logic far_sout_oe,
	input wire logic dev_rx,
	input wire logic far_rx
);
	// ==========================================================
	// Frame trackers
	// Each tracker counts cycles from the first low of a start bit for the longest frame.
	localparam logic [7:0] LAST = 8'(11*CPB-1);
	logic fa, da, next_fa, next_da, fin, din;
	logic [7:0] fc, dc, next_fc, next_dc, fp, dp;
	always_comb begin
		fp = fa ? fc : 8'h00;
		dp = da ? dc : 8'h00;
		fin = fa || !far_sout;
		din = da || !dev_sout;
		next_fa = fin && (fp != LAST);
		next_da = din && (dp != LAST);
		next_fc = fin ? fp + 8'h01 : 8'h00;
		next_dc = din ? dp + 8'h01 : 8'h00;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fa <= 1'b0;
			da <= 1'b0;
			fc <= 8'h00;
			dc <= 8'h00;
		end else begin
			fa <= next_fa;
			da <= next_da;
			fc <= next_fc;
			dc <= next_dc;
		end
	end

	// ==========================================================
	// Assertions
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	AST_RESET_IDLE: assert property ($past(rst) |-> dev_sout && !dev_sout_oe && far_sout)
		else $error("line not idle after reset");
	AST_FAR_DRIVES: assert property (far_sout_oe && (dev_rx == far_sout))
		else $error("far end not driving its line");
	AST_DEV_OE_GATE: assert property (!dev_sout_oe |-> far_rx)
		else $error("undriven device line not high");
	AST_FAR_START: assert property (fin && fp < CPB |-> !far_sout)
		else $error("far start bit too short");
	AST_FAR_STOP: assert property (fa && fp >= 10*CPB |-> far_sout)
		else $error("far stop bit not high");
	AST_FAR_NRZ: assert property (fa && (fp % CPB) != 0 |-> $stable(far_sout))
		else $error("far line changed inside a bit");
	AST_DEV_START: assert property (din && dp < CPB |-> !dev_sout)
		else $error("device start bit too short");
	AST_DEV_NRZ: assert property (da && (dp % CPB) != 0 |-> $stable(dev_sout))
		else $error("device line changed inside a bit");
endmodule
`default_nettype wire

/* File: test/unb_bench.sv */
// Self-checking bench joining the device end and the far end over one link.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module unb_bench;
	import unb_pkg::*;
	localparam int CPB = 4;
	localparam int FRAME = 11*CPB;
	logic clk, rst, wr, rd, irq, tx_address, tx_valid, tx_ready, rx_address, rx_frame_err, rx_valid;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, d;
	logic [7:0] tx_byte, rx_byte, b;
	logic got, a;
	int err_total, n_tests, cyc;
	unb_link_if link();
	unb_device #(.CLKS_PER_BIT(CPB)) i_unb_device(.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .irq(irq), .link(link));
	unb_far_end #(.CLKS_PER_BIT(CPB)) i_unb_far_end(.clk(clk), .rst(rst), .tx_byte(tx_byte),
		.tx_address(tx_address), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte),
		.rx_address(rx_address), .rx_frame_err(rx_frame_err), .rx_valid(rx_valid), .link(link));
	unb_properties #(.CPB(CPB)) i_unb_properties(.clk(clk), .rst(rst), .dev_sout(link.dev_sout),
		.dev_sout_oe(link.dev_sout_oe), .far_sout(link.far_sout), .far_sout_oe(link.far_sout_oe),
		.dev_rx(link.dev_rx), .far_rx(link.far_rx));

	// ==========================================================
	// Clock, timeout and verdict
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			give_verdict();
		end
	end

	// ==========================================================
	// Bus and line tasks
	task automatic wr_reg(input logic [1:0] ra, input logic [15:0] v);
		@(posedge clk);
		addr <= ra;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [1:0] ra, output logic [15:0] v);
		@(posedge clk);
		addr <= ra;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic far_send(input logic [7:0] fb, input logic fa);
		logic ok;
		@(posedge clk);
		tx_byte <= fb;
		tx_address <= fa;
		tx_valid <= 1'b1;
		ok = 1'b0;
		for (int i = 0; i < FRAME && !ok; i++) begin
			@(negedge clk);
			ok = tx_ready;
			@(posedge clk);
		end
		tx_valid <= 1'b0;
		`CHK("far_take", 1'b1, ok)
	endtask
	task automatic wait_far;
		got = 1'b0;
		for (int i = 0; i < 2*FRAME && !got; i++) begin
			@(posedge clk);
			#1 got = rx_valid;
		end
		b = rx_byte;
		a = rx_address;
	endtask
	// Word the far end must see: the frame's character bits, then idle ones.
	function automatic logic [8:0] far_word(input logic [1:0] m, input logic p, input logic [8:0] v);
		int n;
		int w;
		logic [8:0] r;
		n = (m == MODE_7BIT) ? 7 : (m == MODE_8BIT) ? 8 : 9;
		w = p ? n - 1 : n;
		r = 9'h1ff;
		for (int i = 0; i < w; i++) r[i] = v[i];
		if (p) r[w] = ^(v & ((9'h001 << w) - 9'h001));
		return r;
	endfunction

	// ==========================================================
	// Tests
	task automatic t_reset;
		`CHK("irq", 1'b0, irq)
		rd_reg(REG_CTRL, d); `CHK("ctrl", 16'h0000, d)
		rd_reg(REG_MASK, d); `CHK("mask", 16'h0000, d)
		rd_reg(REG_STATUS, d); `CHK("status", 16'h0020, d)
		@(posedge clk);
		#1 `CHK("rdata_idle", 16'h0000, rdata)
		$display("t_reset done");
	endtask
	task automatic t_modes;
		logic [8:0] v, w;
		logic [1:0] m;
		logic p;
		for (int i = 0; i < 8; i++) begin
			m = 2'(i);
			p = i[2];
			v = 9'h0b5 + 9'(i*43);
			w = far_word(m, p && m != MODE_ADDR_FLAG, v);
			wr_reg(REG_CTRL, 16'h0070 | {13'h0000, p, m});
			wr_reg(REG_DATA, {7'h00, v});
			wait_far();
			`CHK("mode_rx", 1'b1, got)
			`CHK("mode_byte", w[7:0], b)
			`CHK("mode_ninth", w[8], a)
			`CHK("mode_ferr", 1'b0, rx_frame_err)
			repeat (2*CPB) @(posedge clk);
		end
		$display("t_modes done");
	endtask
	task automatic t_back_to_back;
		wr_reg(REG_CTRL, 16'h0073);
		wr_reg(REG_DATA, 16'h01a5);
		wr_reg(REG_DATA, 16'h003c);
		// The buffer is still full here, so this byte is dropped.
		wr_reg(REG_DATA, 16'h00ff);
		rd_reg(REG_STATUS, d); `CHK("b2b_busy", 16'h0042, d)
		wait_far(); `CHK("b2b_first", 9'h1a5, {a, b})
		wait_far(); `CHK("b2b_second", 9'h03c, {a, b})
		wait_far(); `CHK("b2b_dropped", 1'b0, got)
		rd_reg(REG_STATUS, d); `CHK("b2b_status", 16'h0022, d)
		$display("t_back_to_back done");
	endtask
	task automatic t_irq;
		wr_reg(REG_MASK, 16'h0000);
		far_send(8'h5a, 1'b1);
		repeat (FRAME + 4) @(posedge clk);
		#1 `CHK("irq_masked", 1'b0, irq)
		wr_reg(REG_MASK, 16'h0001);
		repeat (2) @(posedge clk);
		#1 `CHK("irq_raised", 1'b1, irq)
		rd_reg(REG_STATUS, d); `CHK("irq_status", 16'h0031, d)
		repeat (2) @(posedge clk);
		#1 `CHK("irq_cleared", 1'b0, irq)
		rd_reg(REG_DATA, d); `CHK("rx_data", 16'h015a, d)
		rd_reg(REG_STATUS, d); `CHK("rx_emptied", 16'h0020, d)
		$display("t_irq done");
	endtask
	task automatic t_mode2;
		wr_reg(REG_CTRL, 16'h0076);
		far_send(8'h11, 1'b0);
		repeat (FRAME + 4) @(posedge clk);
		#1 `CHK("m2_data_irq", 1'b0, irq)
		rd_reg(REG_STATUS, d); `CHK("m2_data_status", 16'h0020, d)
		far_send(8'h22, 1'b1);
		repeat (FRAME + 4) @(posedge clk);
		#1 `CHK("m2_addr_irq", 1'b1, irq)
		rd_reg(REG_DATA, d); `CHK("m2_addr_data", 16'h0122, d)
		rd_reg(REG_STATUS, d); `CHK("m2_addr_status", 16'h0021, d)
		$display("t_mode2 done");
	endtask
	task automatic t_errors;
		wr_reg(REG_CTRL, 16'h007f);
		far_send(8'h5a, 1'b1);
		repeat (FRAME + 4) @(posedge clk);
		rd_reg(REG_DATA, d); `CHK("odd_par_data", 16'h005a, d)
		wr_reg(REG_CTRL, 16'h0077);
		far_send(8'h5a, 1'b1);
		repeat (FRAME + 4) @(posedge clk);
		far_send(8'h5a, 1'b1);
		repeat (FRAME + 4) @(posedge clk);
		rd_reg(REG_STATUS, d); `CHK("ovr_status", 16'h003d, d)
		rd_reg(REG_DATA, d); `CHK("par_err_data", 16'h025a, d)
		// Mode 0 takes the far end's low eighth bit as its stop bit.
		wr_reg(REG_CTRL, 16'h0070);
		far_send(8'h35, 1'b1);
		repeat (FRAME + 4) @(posedge clk);
		rd_reg(REG_DATA, d); `CHK("frm_err_data", 16'h0435, d)
		rd_reg(REG_STATUS, d); `CHK("frm_err_status", 16'h0029, d)
		$display("t_errors done");
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		tx_byte = 8'h00;
		tx_address = 1'b0;
		tx_valid = 1'b0;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_modes();
		t_back_to_back();
		t_irq();
		t_mode2();
		t_errors();
		give_verdict();
	end
endmodule
`default_nettype wire
